/* core/pmic_adc_converter_ctrl_regs.sv */
/*
  APB register bank for averaged battery measurements, converter mode and
  undervoltage shutdown control, measurement enables and bias-source control.
  Assumes a 25 MHz clk, synchronous active-low resets (nrst for system reset,
  por_nrst for power-on reset) and measurement results on the same clock.
  Comparator and charger status inputs arrive from analog and are synchronised.
*/
// The APB register port was chosen for this implementation.
// Overview of operation
// RQ1: Battery voltage: bits 11..4 in one byte, bits 3..0 low nibble next.
// RQ2: Charge current presented in the same high byte and low nibble split.
// RQ3: Discharge current presented likewise; upper nibble of low byte reads zero.
// RQ4: All measurement bytes are read-only and clear on system reset.
// RQ5: Converters one, five, six: mode bit 0 auto, 1 forced PWM.
// RQ6: Converters two to four: mode bit 1 defers to shared config bit 4.
// RQ7: Converter mode register resets to 80H; bits 7,6 reserved.
// RQ8: Bit 7 enables off-discharge, default 1, reset only at power-on.
// RQ9: Per converter enable powers device off below 85 percent setting.
// RQ10: Measurement enables at bits 7,6,5,4,0; reset value E1H.
// RQ11: Bits 7..6 set auxiliary bias current 20 to 80 uA, default 11.
// RQ12: Bits 5..4 set thermistor bias current, same encoding, default 11.
// RQ13: Bit 2 selects thermistor pin as battery sensor or plain input.
// RQ14: Bits 1..0 gate thermistor bias: off, charging, ADC phase, always.
// RQ15: Software avoids thermistor bias always-on when auxiliary results matter.
// RQ16: Bias control register resets to F2H only on power-on reset.
// RQ17: Software builds each value as high byte shifted four plus nibble.
`include "pmic_regs_cfg.svh"

module pmic_adc_converter_ctrl_regs (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        por_nrst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Averaged results from the measurement engine, same clock
  input  wire logic        meas_update,
  input  wire logic [11:0] batt_voltage_meas,
  input  wire logic [11:0] charge_current_meas,
  input  wire logic [11:0] discharge_current_meas,
  // Shared converter configuration bit 4, same clock
  input  wire logic        shared_pwm_sel,
  // Asynchronous analog status
  input  wire logic [5:0]  converter_below_85,
  input  wire logic        charging,
  input  wire logic        adc_phase,
  // Control outputs
  output logic [5:0]       converter_force_pwm,
  output logic             off_discharge_en,
  output logic             power_off_req,
  output logic             vbat_meas_en,
  output logic             ibat_meas_en,
  output logic             die_temp_meas_en,
  output logic             aux_pin_measurement_en,
  output logic             thermistor_pin_meas_en,
  output logic [1:0]       aux_pin_zero_bias_sel,
  output logic [1:0]       thermistor_pin_bias_sel,
  output logic             thermistor_pin_is_battery,
  output logic             thermistor_pin_bias_on,
  output logic             aux_pin_zero_bias_on
);
  import pmic_regs_pkg::*;

  regs_state_s st_q;
  regs_state_s st_d;

  logic [7:0] idx;
  logic       addr_ok;
  logic       access;
  logic       wr_en;
  logic [7:0] rd_byte;
  logic       rd_hit;

  // Word index decode; misaligned or out-of-window addresses are unmapped
  assign idx     = paddr[9:2];
  assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign access  = psel && penable;
  // Write lands at the edge where the master sees pready
  assign wr_en   = access && st_q.pready && pwrite && pstrb[0] && addr_ok;

  // Read mux; upper nibble of low result bytes and misaligned or unmapped reads return zero
  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = addr_ok;
    case (idx)
      `IDX_VBAT_HI:   rd_byte = st_q.vbat[11:4];              // RQ1
      `IDX_VBAT_LO:   rd_byte = {4'h0, st_q.vbat[3:0]};       // RQ1
      `IDX_ICHG_HI:   rd_byte = st_q.ichg[11:4];              // RQ2
      `IDX_ICHG_LO:   rd_byte = {4'h0, st_q.ichg[3:0]};       // RQ2
      `IDX_IDIS_HI:   rd_byte = st_q.idis[11:4];              // RQ3
      `IDX_IDIS_LO:   rd_byte = {4'h0, st_q.idis[3:0]};       // RQ3
      `IDX_CONV_MODE: rd_byte = st_q.conv_mode;
      `IDX_DIS_UV:    rd_byte = st_q.dis_uv;
      `IDX_MEAS_EN:   rd_byte = st_q.meas_en;
      `IDX_BIAS_CTRL: rd_byte = st_q.bias_ctrl;
      default:        rd_hit  = 1'b0;
    endcase
    if (!addr_ok) begin
      rd_byte = 8'h00;
    end
  end

  // Next state of the whole bank
  always_comb begin
    st_d = st_q;

    // APB: one wait state, answer registered
    if (access && !st_q.pready) begin
      st_d.pready  = 1'b1;
      st_d.prdata  = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      st_d.pslverr = !rd_hit;
    end else begin
      st_d.pready  = 1'b0;
      st_d.prdata  = 32'h0000_0000;
      st_d.pslverr = 1'b0;
    end

    // Results captured whole so high and low bytes always match
    if (meas_update) begin
      st_d.vbat = batt_voltage_meas;                          // RQ1
      st_d.ichg = charge_current_meas;                        // RQ2
      st_d.idis = discharge_current_meas;                     // RQ3
    end

    // Software writes; measurement bytes have no write path
    if (wr_en) begin
      case (idx)
        `IDX_CONV_MODE: st_d.conv_mode = pwdata[7:0];         // RQ7
        `IDX_DIS_UV:    st_d.dis_uv    = pwdata[7:0];         // RQ9
        `IDX_MEAS_EN:   st_d.meas_en   = pwdata[7:0];         // RQ10
        `IDX_BIAS_CTRL: st_d.bias_ctrl = pwdata[7:0];
        default:        st_d.conv_mode = st_q.conv_mode;      // RQ4
      endcase
    end

    // Two-flop synchronisers for analog status
    st_d.below_s1 = converter_below_85;
    st_d.below_s2 = st_q.below_s1;
    st_d.chg_s1   = charging;
    st_d.chg_s2   = st_q.chg_s1;
    st_d.adc_s1   = adc_phase;
    st_d.adc_s2   = st_q.adc_s1;

    // Converter mode: bits 1..3 defer to shared config when set
    st_d.force_pwm[0] = st_q.conv_mode[0];                              // RQ5
    st_d.force_pwm[1] = st_q.conv_mode[1] && shared_pwm_sel;            // RQ6
    st_d.force_pwm[2] = st_q.conv_mode[2] && shared_pwm_sel;            // RQ6
    st_d.force_pwm[3] = st_q.conv_mode[3] && shared_pwm_sel;            // RQ6
    st_d.force_pwm[4] = st_q.conv_mode[4];                              // RQ5
    st_d.force_pwm[5] = st_q.conv_mode[5];                              // RQ5

    // Undervoltage shutdown request holds until a reset clears it
    if (|(st_q.below_s2 & st_q.dis_uv[5:0])) begin
      st_d.power_off_req = 1'b1;                              // RQ9
    end

    // Thermistor bias gating
    case (st_q.bias_ctrl[1:0])
      `THERM_BIAS_OFF:    st_d.therm_bias_on = 1'b0;          // RQ14
      `THERM_BIAS_CHG:    st_d.therm_bias_on = st_q.chg_s2;   // RQ14
      `THERM_BIAS_ADC:    st_d.therm_bias_on = st_q.adc_s2;   // RQ14
      `THERM_BIAS_ALWAYS: st_d.therm_bias_on = 1'b1;          // RQ14
      default:            st_d.therm_bias_on = 1'b0;
    endcase
    // Aux source only during its conversion; shares the source with thermistor
    st_d.aux_bias_on = st_q.meas_en[`POS_AUX_MEAS_EN] && st_q.adc_s2;

    // System reset: results, mode and enables; power-on registers survive
    if (!nrst) begin
      st_d.pready        = 1'b0;
      st_d.prdata        = 32'h0000_0000;
      st_d.pslverr       = 1'b0;
      st_d.vbat          = `RST_MEAS;                         // RQ4
      st_d.ichg          = `RST_MEAS;                         // RQ4
      st_d.idis          = `RST_MEAS;                         // RQ4
      st_d.conv_mode     = `RST_CONV_MODE;                    // RQ7
      st_d.meas_en       = `RST_MEAS_EN;                      // RQ10
      st_d.force_pwm     = 6'h00;
      st_d.power_off_req = 1'b0;
      st_d.therm_bias_on = 1'b0;
      st_d.aux_bias_on   = 1'b0;
    end
    // Power-on reset clears all state, then loads the reset value of every register
    if (!por_nrst) begin
      st_d               = '0;
      st_d.vbat          = `RST_MEAS;
      st_d.ichg          = `RST_MEAS;
      st_d.idis          = `RST_MEAS;
      st_d.conv_mode     = `RST_CONV_MODE;
      st_d.dis_uv        = `RST_DIS_UV;                       // RQ8
      st_d.meas_en       = `RST_MEAS_EN;
      st_d.bias_ctrl     = `RST_BIAS_CTRL;                    // RQ16
    end
  end

  // State register; resets are synchronous and folded into st_d
  always_ff @(posedge clk) begin
    st_q <= st_d;
  end

  // Outputs straight from state flops; thermistor_pin_is_battery is the inverted role bit
  assign pready                    = st_q.pready;
  assign prdata                    = st_q.prdata;
  assign pslverr                   = st_q.pslverr;
  assign converter_force_pwm       = st_q.force_pwm;
  assign off_discharge_en          = st_q.dis_uv[`POS_OFF_DIS];          // RQ8
  assign power_off_req             = st_q.power_off_req;
  assign vbat_meas_en              = st_q.meas_en[7];                    // RQ10
  assign ibat_meas_en              = st_q.meas_en[6];                    // RQ10
  assign die_temp_meas_en          = st_q.meas_en[5];                    // RQ10
  assign aux_pin_measurement_en    = st_q.meas_en[`POS_AUX_MEAS_EN];     // RQ10
  assign thermistor_pin_meas_en    = st_q.meas_en[0];                    // RQ10
  assign aux_pin_zero_bias_sel     = st_q.bias_ctrl[7:6];                // RQ11
  assign thermistor_pin_bias_sel   = st_q.bias_ctrl[5:4];                // RQ12
  assign thermistor_pin_is_battery = !st_q.bias_ctrl[`POS_THERM_ROLE];   // RQ13
  assign thermistor_pin_bias_on    = st_q.therm_bias_on;
  assign aux_pin_zero_bias_on      = st_q.aux_bias_on;

  // Checks
  default clocking cb @(posedge clk);
  endclocking

  property p_vbat_lo_split;
    disable iff (!nrst || !por_nrst)
    access && !pwrite && !st_q.pready && addr_ok && idx == `IDX_VBAT_LO
      |=> prdata == {28'h000_0000, $past(st_q.vbat[3:0])};
  endproperty
  a_vbat_lo_split: assert property (p_vbat_lo_split) else $error("vbat low nibble wrong"); // RQ1

  property p_ichg_hi_split;
    disable iff (!nrst || !por_nrst)
    access && !pwrite && !st_q.pready && addr_ok && idx == `IDX_ICHG_HI && !meas_update
      |=> prdata == {24'h00_0000, st_q.ichg[11:4]} && !pslverr;
  endproperty
  a_ichg_hi_split: assert property (p_ichg_hi_split) else $error("ichg high byte wrong"); // RQ2

  property p_idis_capture;
    disable iff (!nrst || !por_nrst)
    meas_update |=> st_q.idis == $past(discharge_current_meas);
  endproperty
  a_idis_capture: assert property (p_idis_capture) else $error("idis not captured"); // RQ3

  property p_ro_write;
    disable iff (!nrst || !por_nrst)
    wr_en && idx == `IDX_VBAT_HI && !meas_update |=> $stable(st_q.vbat);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("result byte was written"); // RQ4

  property p_pwm_direct;
    disable iff (!nrst || !por_nrst)
    1'b1 |=> converter_force_pwm[5] == $past(st_q.conv_mode[5]);
  endproperty
  a_pwm_direct: assert property (p_pwm_direct) else $error("converter six mode wrong"); // RQ5

  property p_pwm_shared;
    disable iff (!nrst || !por_nrst)
    1'b1 |=> converter_force_pwm[2] == ($past(st_q.conv_mode[2]) && $past(shared_pwm_sel));
  endproperty
  a_pwm_shared: assert property (p_pwm_shared) else $error("shared mode wrong"); // RQ6

  property p_conv_reset;
    disable iff (!por_nrst)
    !nrst |=> st_q.conv_mode == `RST_CONV_MODE;
  endproperty
  a_conv_reset: assert property (p_conv_reset) else $error("mode reset value wrong"); // RQ7

  property p_dis_keeps;
    disable iff (!por_nrst)
    !nrst && !wr_en |=> st_q.dis_uv == $past(st_q.dis_uv);
  endproperty
  a_dis_keeps: assert property (p_dis_keeps) else $error("system reset hit dis_uv"); // RQ8

  property p_power_off;
    disable iff (!nrst || !por_nrst)
    |(st_q.below_s2 & st_q.dis_uv[5:0]) |=> power_off_req [*2];
  endproperty
  a_power_off: assert property (p_power_off) else $error("no power off request"); // RQ9

  property p_meas_write;
    disable iff (!nrst || !por_nrst)
    wr_en && idx == `IDX_MEAS_EN |=> vbat_meas_en == $past(pwdata[7]);
  endproperty
  a_meas_write: assert property (p_meas_write) else $error("enable write lost"); // RQ10

  // Bias flop still shows reset one cycle after release, so start after it
  property p_therm_always;
    disable iff (!nrst || !por_nrst)
    nrst && st_q.bias_ctrl[1:0] == `THERM_BIAS_ALWAYS
      ##1 st_q.bias_ctrl[1:0] == `THERM_BIAS_ALWAYS
      |-> thermistor_pin_bias_on;
  endproperty
  a_therm_always: assert property (p_therm_always) else $error("thermistor bias off"); // RQ14

  property p_bias_por;
    !por_nrst |=> st_q.bias_ctrl == `RST_BIAS_CTRL && thermistor_pin_bias_sel == 2'h3;
  endproperty
  a_bias_por: assert property (p_bias_por) else $error("bias reset value wrong"); // RQ16

  property p_apb_wait;
    disable iff (!nrst || !por_nrst)
    access && !st_q.pready |=> pready ##1 !pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb answer timing wrong");

  // Field writes reach the pins at the landing edge; checked at the next edge
  property p_aux_sel_write;
    disable iff (!nrst || !por_nrst)
    wr_en && idx == `IDX_BIAS_CTRL |=> aux_pin_zero_bias_sel == $past(pwdata[7:6]);
  endproperty
  a_aux_sel_write: assert property (p_aux_sel_write) else $error("aux bias select lost"); // RQ11

  property p_therm_sel_write;
    disable iff (!nrst || !por_nrst)
    wr_en && idx == `IDX_BIAS_CTRL |=> thermistor_pin_bias_sel == $past(pwdata[5:4]);
  endproperty
  a_therm_sel_write: assert property (p_therm_sel_write) else $error("bias select lost"); // RQ12

  property p_role_write;
    disable iff (!nrst || !por_nrst)
    wr_en && idx == `IDX_BIAS_CTRL
      |=> thermistor_pin_is_battery == !$past(pwdata[`POS_THERM_ROLE]);
  endproperty
  a_role_write: assert property (p_role_write) else $error("pin role select lost"); // RQ13

  property p_off_dis_write;
    disable iff (!nrst || !por_nrst)
    wr_en && idx == `IDX_DIS_UV |=> off_discharge_en == $past(pwdata[`POS_OFF_DIS]);
  endproperty
  a_off_dis_write: assert property (p_off_dis_write) else $error("discharge enable lost"); // RQ8

  // No shutdown request unless an enabled converter sits below threshold
  property p_uv_quiet;
    disable iff (!nrst || !por_nrst)
    !power_off_req && !(|(st_q.below_s2 & st_q.dis_uv[5:0])) |=> !power_off_req;
  endproperty
  a_uv_quiet: assert property (p_uv_quiet) else $error("spurious power off"); // RQ9

  property p_therm_off;
    disable iff (!nrst || !por_nrst)
    st_q.bias_ctrl[1:0] == `THERM_BIAS_OFF |=> !thermistor_pin_bias_on;
  endproperty
  a_therm_off: assert property (p_therm_off) else $error("thermistor bias not off"); // RQ14

  c_conv_write: cover property (@(posedge clk) wr_en && idx == `IDX_CONV_MODE);
  c_vbat_read:  cover property (@(posedge clk) pready && !pwrite && idx == `IDX_VBAT_HI);
  c_power_off:  cover property (@(posedge clk) $rose(power_off_req));
  c_unmapped:   cover property (@(posedge clk) pslverr);
  c_both_bias:  cover property (@(posedge clk) thermistor_pin_bias_on && aux_pin_zero_bias_on);

endmodule

/* core/pmic_regs_cfg.svh */
/*
  Offsets, field positions and reset values of the measurement, converter
  and bias-control register bank. Assumes inclusion by bare name.
*/
`ifndef PMIC_REGS_CFG_SVH
`define PMIC_REGS_CFG_SVH

// Register indices; byte address on APB is four times the index
`define IDX_VBAT_HI      8'h78
`define IDX_VBAT_LO      8'h79
`define IDX_ICHG_HI      8'h7A
`define IDX_ICHG_LO      8'h7B
`define IDX_IDIS_HI      8'h7C
`define IDX_IDIS_LO      8'h7D
`define IDX_CONV_MODE    8'h80
`define IDX_DIS_UV       8'h81
`define IDX_MEAS_EN      8'h82
`define IDX_BIAS_CTRL    8'h84

// Reset values
`define RST_MEAS         12'h000
`define RST_CONV_MODE    8'h80
`define RST_DIS_UV       8'h80
`define RST_MEAS_EN      8'hE1
`define RST_BIAS_CTRL    8'hF2

// Field positions
`define POS_OFF_DIS      7
`define POS_THERM_ROLE   2
`define POS_AUX_MEAS_EN  4
`define POS_SHARED_PWM   4

// Thermistor bias gating codes
`define THERM_BIAS_OFF    2'h0
`define THERM_BIAS_CHG    2'h1
`define THERM_BIAS_ADC    2'h2
`define THERM_BIAS_ALWAYS 2'h3

`endif

/* core/pmic_regs_pkg.sv */
/*
  Types shared by the measurement and converter control register bank.
  Assumes nothing of its surroundings.
*/
package pmic_regs_pkg;

  // Whole state of the register bank, registered as one word
  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic [11:0] vbat;
    logic [11:0] ichg;
    logic [11:0] idis;
    logic [7:0]  conv_mode;
    logic [7:0]  dis_uv;
    logic [7:0]  meas_en;
    logic [7:0]  bias_ctrl;
    logic [5:0]  below_s1;
    logic [5:0]  below_s2;
    logic        chg_s1;
    logic        chg_s2;
    logic        adc_s1;
    logic        adc_s2;
    logic [5:0]  force_pwm;
    logic        therm_bias_on;
    logic        aux_bias_on;
    logic        power_off_req;
  } regs_state_s;

endpackage

/* testbench/pmic_adc_converter_ctrl_regs_tb.sv */
/*
  Self-checking bench for the measurement, converter and bias register bank.
  Assumes the bank answers APB with one wait state and index addressing.
*/
`include "pmic_regs_cfg.svh"
module pmic_adc_converter_ctrl_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, nrst, por_nrst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr, batt_voltage_meas, charge_current_meas, discharge_current_meas;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  pstrb;
  logic        meas_update, shared_pwm_sel, charging, adc_phase, rerr;
  logic [5:0]  converter_below_85, converter_force_pwm;
  logic        off_discharge_en, power_off_req, vbat_meas_en, ibat_meas_en;
  logic        die_temp_meas_en, aux_pin_measurement_en, thermistor_pin_meas_en;
  logic [1:0]  aux_pin_zero_bias_sel, thermistor_pin_bias_sel;
  logic        thermistor_pin_is_battery, thermistor_pin_bias_on, aux_pin_zero_bias_on;
  int          err_total, checks;
  logic [11:0] val12;

  typedef struct {logic [7:0] idx; logic [7:0] rst; logic [7:0] wd; logic [7:0] rb;} row_s;
  row_s rows[10] = '{
    '{`IDX_VBAT_HI, 8'h00, 8'hFF, 8'h00}, '{`IDX_VBAT_LO, 8'h00, 8'hFF, 8'h00},
    '{`IDX_ICHG_HI, 8'h00, 8'hFF, 8'h00}, '{`IDX_ICHG_LO, 8'h00, 8'hFF, 8'h00},
    '{`IDX_IDIS_HI, 8'h00, 8'hFF, 8'h00}, '{`IDX_IDIS_LO, 8'h00, 8'hFF, 8'h00},
    '{`IDX_CONV_MODE, 8'h80, 8'hBF, 8'hBF}, '{`IDX_DIS_UV, 8'h80, 8'h3F, 8'h3F},
    '{`IDX_MEAS_EN, 8'hE1, 8'h11, 8'h11}, '{`IDX_BIAS_CTRL, 8'hF2, 8'h77, 8'h77}};

  pmic_adc_converter_ctrl_regs i_dut (.clk, .nrst, .por_nrst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .meas_update, .batt_voltage_meas,
    .charge_current_meas, .discharge_current_meas, .shared_pwm_sel, .converter_below_85,
    .charging, .adc_phase, .converter_force_pwm, .off_discharge_en, .power_off_req,
    .vbat_meas_en, .ibat_meas_en, .die_temp_meas_en, .aux_pin_measurement_en,
    .thermistor_pin_meas_en, .aux_pin_zero_bias_sel, .thermistor_pin_bias_sel,
    .thermistor_pin_is_battery, .thermistor_pin_bias_on, .aux_pin_zero_bias_on);

  // 25 MHz clock
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end

  // Wide enough to carry the error flag beside the read word
  task chk(input logic [32:0] g, input logic [32:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task apb(input logic w, input logic [7:0] idx, input logic [7:0] wd, input logic s);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd}; pstrb <= {3'b000, s};
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk(0, 1);
    rdat = prdata; rerr = pslverr;
    psel <= 0; penable <= 0;
  endtask

  task rd_chk(input logic [7:0] idx, input logic [7:0] e);
    apb(0, idx, 8'h00, 1);
    chk({rerr, rdat}, {1'b0, 24'h0, e});
  endtask

  // Either reset held for 8 cycles
  task rst(input logic por);
    @(posedge clk);
    nrst <= 0; por_nrst <= !por;
    repeat (8) @(posedge clk);
    nrst <= 1; por_nrst <= 1;
  endtask

  task wt;
    repeat (5) @(posedge clk);
  endtask

  task results;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Whole run is a few hundred cycles; cut a hang at 20000 cycles, well beyond that
  initial begin
    #(40 * 20000);
    err_total++;
    results();
  end

  initial begin
    {nrst, por_nrst, psel, penable, pwrite, meas_update, shared_pwm_sel} = 0;
    {charging, adc_phase, paddr, pwdata, pstrb, converter_below_85} = 0;
    {batt_voltage_meas, charge_current_meas, discharge_current_meas} = 0;
    err_total = 0; checks = 0;
    rst(1);
    // Reset values, write, read back; result bytes ignore writes
    foreach (rows[i]) begin
      rd_chk(rows[i].idx, rows[i].rst);
      apb(1, rows[i].idx, rows[i].wd, 1);
      rd_chk(rows[i].idx, rows[i].rb);
    end
    $display("test register table done");
    wt();
    chk(converter_force_pwm, 6'h31);
    chk({vbat_meas_en, ibat_meas_en, die_temp_meas_en, aux_pin_measurement_en,
         thermistor_pin_meas_en}, 5'b00011);
    chk({aux_pin_zero_bias_sel, thermistor_pin_bias_sel}, 4'b0111);
    chk(thermistor_pin_is_battery, 1'b0);
    chk(off_discharge_en, 1'b0);
    shared_pwm_sel <= 1;
    wt();
    chk(converter_force_pwm, 6'h3F);
    $display("test controls done");
    // Capture and split of all three results
    @(posedge clk);
    meas_update <= 1; batt_voltage_meas <= 12'hABC;
    charge_current_meas <= 12'h123; discharge_current_meas <= 12'hFED;
    @(posedge clk);
    meas_update <= 0; batt_voltage_meas <= 12'h555;
    rd_chk(`IDX_VBAT_HI, 8'hAB);
    rd_chk(`IDX_VBAT_LO, 8'h0C);
    rd_chk(`IDX_ICHG_HI, 8'h12);
    rd_chk(`IDX_ICHG_LO, 8'h03);
    rd_chk(`IDX_IDIS_HI, 8'hFE);
    rd_chk(`IDX_IDIS_LO, 8'h0D);
    // Software view: high byte shifted up, low nibble below it
    apb(0, `IDX_VBAT_HI, 8'h00, 1);
    val12 = {rdat[7:0], 4'h0};
    apb(0, `IDX_VBAT_LO, 8'h00, 1);
    val12 = val12 | {8'h00, rdat[3:0]};
    chk(val12, 12'hABC);
    $display("test measurements done");
    // Unmapped index and masked strobe
    apb(0, 8'h83, 8'h00, 1);
    chk({rerr, rdat}, {1'b1, 32'h0});
    apb(1, `IDX_MEAS_EN, 8'hE0, 0);
    rd_chk(`IDX_MEAS_EN, 8'h11);
    // Thermistor bias gating over all four codes
    for (int c = 0; c < 4; c++) begin
      apb(1, `IDX_BIAS_CTRL, {6'h3C, c[1:0]}, 1);
      charging <= 1; adc_phase <= 0;
      wt();
      chk(thermistor_pin_bias_on, c[0]);
      chk(aux_pin_zero_bias_on, 1'b0);
      charging <= 0; adc_phase <= 1;
      wt();
      chk(thermistor_pin_bias_on, c[1]);
      chk(aux_pin_zero_bias_on, 1'b1);
    end
    $display("test bias gating done");
    // Undervoltage shutdown only for enabled converters, then sticky
    apb(1, `IDX_DIS_UV, 8'h01, 1);
    converter_below_85 <= 6'h3E;
    wt();
    chk(power_off_req, 1'b0);
    converter_below_85 <= 6'h01;
    wt();
    chk(power_off_req, 1'b1);
    converter_below_85 <= 6'h00;
    wt();
    chk(power_off_req, 1'b1);
    $display("test undervoltage done");
    // System reset keeps power-on-only registers
    rst(0);
    wt();
    chk(power_off_req, 1'b0);
    rd_chk(`IDX_DIS_UV, 8'h01);
    rd_chk(`IDX_BIAS_CTRL, 8'hF3);
    rd_chk(`IDX_CONV_MODE, 8'h80);
    rd_chk(`IDX_MEAS_EN, 8'hE1);
    rd_chk(`IDX_VBAT_HI, 8'h00);
    rd_chk(`IDX_IDIS_LO, 8'h00);
    rst(1);
    wt();
    rd_chk(`IDX_DIS_UV, 8'h80);
    rd_chk(`IDX_BIAS_CTRL, 8'hF2);
    chk(off_discharge_en, 1'b1);
    chk({aux_pin_zero_bias_sel, thermistor_pin_bias_sel}, 4'hF);
    chk(thermistor_pin_is_battery, 1'b1);
    $display("test resets done");
    results();
  end
endmodule
